// ### inc/esiu_pkg.sv
// Package for the extended stack instruction unit: opcodes, field layout and shared types.
package esiu_pkg;
	localparam int ADDR_W = 12;
	localparam int PC_W = 21;
	localparam logic [7:0] OP_ADD = 8'hE8;
	localparam logic [7:0] OP_SUB = 8'hE9;
	localparam logic [7:0] OP_PUSH = 8'hFA;
	localparam logic [7:0] OP_PUSH_ALT = 8'hEA;
	localparam logic [7:0] OP_MOVE = 8'hEB;
	localparam logic [15:0] OP_CALL_IND = 16'h0014;
	localparam logic [3:0] SECOND_WORD_TAG = 4'hF;
	localparam logic [1:0] SEL_FRAME_RET = 2'h3;
	localparam logic [1:0] SEL_FRAME = 2'h2;
	localparam logic [7:0] INDEX_LIMIT = 8'h5F;
	localparam int MOVE_SEL_BIT = 7;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [ADDR_W-1:0] PTR_ONE = 12'h001;
	localparam logic [ADDR_W-1:0] PC_LOW_ADDR = 12'hFF9;
	localparam logic [ADDR_W-1:0] TOS_LOW_ADDR = 12'hFFD;
	localparam logic [ADDR_W-1:0] TOS_UP_ADDR = 12'hFFF;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

	typedef enum {ESIU_IDLE, ESIU_RET_WAIT, ESIU_CALL_WAIT, ESIU_MOVE_WORD2} esiu_state_t;

	typedef struct packed {
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} esiu_dwr_t;

	typedef struct packed {
		logic push;
		logic [PC_W-1:0] push_val;
		logic pop;
	} esiu_stack_t;
endpackage

// ### core/esiu_indirect_check.sv
`timescale 1ns/1ps
// Flags addresses that fall on indirect-access or protected special registers.
module esiu_indirect_check #(
	parameter logic [11:0] INDIRECT_LO = 12'hFDB, // First indirect-access register.
	parameter logic [11:0] INDIRECT_HI = 12'hFEF  // Last indirect-access register.
) (
	input wire logic [11:0] i_addr, // Data address to classify.
	output logic o_indirect,        // Address is an indirect-access register.
	output logic o_protected        // Address is counter low or a return stack top byte.
);
	always_comb begin
		o_indirect = (i_addr >= INDIRECT_LO) && (i_addr <= INDIRECT_HI);
		o_protected = (i_addr == esiu_pkg::PC_LOW_ADDR) ||
			((i_addr >= esiu_pkg::TOS_LOW_ADDR) && (i_addr <= esiu_pkg::TOS_UP_ADDR));
	end
endmodule

// ### core/esiu_core.sv
`timescale 1ns/1ps
// Decode and execute logic for the eight extension instructions.
module esiu_core #(
	parameter int PTR_COUNT = 3 // Number of file-select pointers.
) (
	input wire logic i_ref_clk,                      // Core instruction clock.
	input wire logic i_resetn,                       // Synchronous reset, active low.
	input wire logic i_ce,                           // Clock enable; low freezes all state.
	input wire logic i_extension_enable_fuse,        // Configuration fuse, from a pin.
	input wire logic i_instr_valid,                  // Instruction word is present.
	input wire logic [15:0] i_instr,                 // Fetched instruction word.
	input wire logic [7:0] i_working_register,       // Working register value.
	input wire logic [7:0] i_counter_latch_high,     // Counter latch high byte.
	input wire logic [7:0] i_counter_latch_upper,    // Counter latch upper byte.
	input wire logic [esiu_pkg::PC_W-1:0] i_pc,      // Address of current instruction.
	input wire logic [esiu_pkg::PC_W-1:0] i_return_stack_top, // Return stack top.
	input wire logic [7:0] i_rdata,                  // Data memory read data.
	input wire logic i_access_bit,                   // Access-bank bit of a standard instruction.
	input wire logic [7:0] i_file_arg,               // File argument of a standard instruction.
	output logic o_ext_taken,                        // Word was consumed as an extension opcode.
	output logic o_busy,                             // Second cycle in progress.
	output logic [esiu_pkg::ADDR_W-1:0] o_raddr,     // Data memory read address.
	output esiu_pkg::esiu_dwr_t o_dwr,               // Data memory write.
	output esiu_pkg::esiu_stack_t o_stack,           // Return stack request.
	output logic o_pc_load,                          // Load the program counter.
	output logic [esiu_pkg::PC_W-1:0] o_pc_value,    // New program counter.
	output logic o_indexed_mode,                     // Standard file argument is frame-relative.
	output logic [esiu_pkg::ADDR_W-1:0] o_indexed_addr, // Frame-relative address for standard set.
	output logic [esiu_pkg::ADDR_W-1:0] o_stack_frame_pointer, // Frame pointer value.
	output logic [esiu_pkg::ADDR_W*PTR_COUNT-1:0] o_file_select_pointer // All pointers.
);
	localparam int ADDR_W = esiu_pkg::ADDR_W;

	logic fuse_meta;
	logic fuse;
	esiu_pkg::esiu_state_t state;
	logic [ADDR_W-1:0] ptr [PTR_COUNT];
	logic [7:0] op_hi;
	logic [1:0] sel;
	logic [ADDR_W-1:0] lit6;
	logic [ADDR_W-1:0] src_addr;
	logic [ADDR_W-1:0] dst_addr;
	logic dst_indirect;
	logic dst_protected;
	logic src_indirect;
	logic move_indexed;
	logic is_add;
	logic is_sub;
	logic is_push;
	logic is_move;
	logic is_call;
	logic word2_ok;

	// The fuse is a pin level, so it is synchronised before any decode uses it.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			fuse_meta <= 1'b0;
			fuse <= 1'b0;
		end else if (i_ce) begin
			fuse_meta <= i_extension_enable_fuse;
			fuse <= fuse_meta;
		end
	end

	always_comb begin
		op_hi = i_instr[15:8];
		sel = i_instr[7:6];
		lit6 = {6'h00, i_instr[5:0]};
		is_add = fuse && i_instr_valid && (state == esiu_pkg::ESIU_IDLE) && (op_hi == esiu_pkg::OP_ADD);
		is_sub = fuse && i_instr_valid && (state == esiu_pkg::ESIU_IDLE) && (op_hi == esiu_pkg::OP_SUB);
		// Both printed push encodings are accepted; they do not collide with other extension opcodes.
		is_push = fuse && i_instr_valid && (state == esiu_pkg::ESIU_IDLE) &&
			((op_hi == esiu_pkg::OP_PUSH) || (op_hi == esiu_pkg::OP_PUSH_ALT));
		is_move = fuse && i_instr_valid && (state == esiu_pkg::ESIU_IDLE) && (op_hi == esiu_pkg::OP_MOVE);
		is_call = fuse && i_instr_valid && (state == esiu_pkg::ESIU_IDLE) && (i_instr == esiu_pkg::OP_CALL_IND);
		word2_ok = i_instr_valid && (i_instr[15:12] == esiu_pkg::SECOND_WORD_TAG);
		src_addr = ptr[esiu_pkg::SEL_FRAME] + {5'h00, i_instr[6:0]};
		dst_addr = move_indexed ? ptr[esiu_pkg::SEL_FRAME] + {5'h00, i_instr[6:0]} : i_instr[11:0];
	end

	esiu_indirect_check u_src_check (
		.i_addr(o_raddr),
		.o_indirect(src_indirect),
		.o_protected()
	);

	esiu_indirect_check u_dst_check (
		.i_addr(dst_addr),
		.o_indirect(dst_indirect),
		.o_protected(dst_protected)
	);

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			state <= esiu_pkg::ESIU_IDLE;
		end else if (i_ce) begin
			case (state)
				esiu_pkg::ESIU_IDLE: begin
					if ((is_add || is_sub) && sel == esiu_pkg::SEL_FRAME_RET) begin
						state <= esiu_pkg::ESIU_RET_WAIT;
					end else if (is_call) begin
						state <= esiu_pkg::ESIU_CALL_WAIT;
					end else if (is_move) begin
						state <= esiu_pkg::ESIU_MOVE_WORD2;
					end
				end
				esiu_pkg::ESIU_MOVE_WORD2: begin
					if (i_instr_valid) begin
						state <= esiu_pkg::ESIU_IDLE;
					end
				end
				default: begin
					state <= esiu_pkg::ESIU_IDLE;
				end
			endcase
		end
	end

	// Pointer arithmetic wraps at the pointer width and never reaches a status flag.
	genvar gi;
	generate
		for (gi = 0; gi < PTR_COUNT; gi++) begin : g_ptr
			always_ff @(posedge i_ref_clk) begin
				if (!i_resetn) begin
					ptr[gi] <= '0;
				end else if (i_ce) begin
					if (is_add && (sel == 2'(gi) || (sel == esiu_pkg::SEL_FRAME_RET && gi == esiu_pkg::SEL_FRAME))) begin
						ptr[gi] <= ptr[gi] + lit6;
					end else if (is_sub && (sel == 2'(gi) ||
						(sel == esiu_pkg::SEL_FRAME_RET && gi == esiu_pkg::SEL_FRAME))) begin
						ptr[gi] <= ptr[gi] - lit6;
					end else if (is_push && gi == esiu_pkg::SEL_FRAME) begin
						ptr[gi] <= ptr[gi] - esiu_pkg::PTR_ONE;
					end
				end
			end
			assign o_file_select_pointer[gi*ADDR_W +: ADDR_W] = ptr[gi];
		end
	endgenerate

	// Source address and move kind are held for the second word.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_raddr <= '0;
			move_indexed <= 1'b0;
		end else if (i_ce && is_move) begin
			o_raddr <= src_addr;
			move_indexed <= i_instr[esiu_pkg::MOVE_SEL_BIT];
		end
	end

	// Data memory writes; a move whose second word is malformed or whose target is forbidden writes nothing.
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_dwr <= '0;
		end else if (i_ce) begin
			o_dwr.we <= 1'b0;
			if (is_push) begin
				o_dwr.we <= 1'b1;
				o_dwr.addr <= ptr[esiu_pkg::SEL_FRAME];
				o_dwr.wdata <= i_instr[7:0];
			end else if (state == esiu_pkg::ESIU_MOVE_WORD2 && word2_ok) begin
				o_dwr.we <= !(move_indexed && dst_indirect) && !dst_protected;
				o_dwr.addr <= dst_addr;
				o_dwr.wdata <= src_indirect ? esiu_pkg::ZERO_BYTE : i_rdata;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_stack <= '0;
			o_pc_load <= 1'b0;
			o_pc_value <= '0;
		end else if (i_ce) begin
			o_stack.push <= 1'b0;
			o_stack.pop <= 1'b0;
			o_pc_load <= 1'b0;
			if ((is_add || is_sub) && sel == esiu_pkg::SEL_FRAME_RET) begin
				o_stack.pop <= 1'b1;
				o_pc_load <= 1'b1;
				o_pc_value <= i_return_stack_top;
			end else if (is_call) begin
				o_stack.push <= 1'b1;
				o_stack.push_val <= i_pc + esiu_pkg::PC_STEP;
				o_pc_load <= 1'b1;
				o_pc_value <= {i_counter_latch_upper[4:0], i_counter_latch_high, i_working_register};
			end
		end
	end

	always_comb begin
		o_ext_taken = is_add || is_sub || is_push || is_move || is_call ||
			(state == esiu_pkg::ESIU_MOVE_WORD2 && i_instr_valid);
		o_busy = (state != esiu_pkg::ESIU_IDLE);
		o_indexed_mode = fuse && !i_access_bit && (i_file_arg <= esiu_pkg::INDEX_LIMIT);
		o_indexed_addr = ptr[esiu_pkg::SEL_FRAME] + {4'h0, i_file_arg};
		o_stack_frame_pointer = ptr[esiu_pkg::SEL_FRAME];
	end

	a_fuse_gate: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		!fuse |-> !o_ext_taken && !o_indexed_mode) else $error("extension used with fuse clear");
	a_add_ptr: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_ce && is_add && sel == 2'h0) |=> ptr[0] == $past(ptr[0]) + $past(lit6)) else $error("add wrong");
	a_sub_ptr: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_ce && is_sub && sel == 2'h1) |=> ptr[1] == $past(ptr[1]) - $past(lit6)) else $error("sub wrong");
	a_ret_frame: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_ce && is_add && sel == esiu_pkg::SEL_FRAME_RET) |=> o_pc_load && o_stack.pop && o_busy)
		else $error("add-and-return missing");
	a_ret_two: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_ce && state == esiu_pkg::ESIU_RET_WAIT) |-> !o_ext_taken ##1 !o_busy || !i_ce)
		else $error("return not two cycles");
	a_call_push: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_ce && is_call) |=> o_stack.push && o_stack.push_val == $past(i_pc) + esiu_pkg::PC_STEP)
		else $error("call push wrong");
	a_push_write: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_ce && is_push) |=> o_dwr.we && o_dwr.addr == $past(ptr[esiu_pkg::SEL_FRAME]) &&
		ptr[esiu_pkg::SEL_FRAME] == o_dwr.addr - esiu_pkg::PTR_ONE) else $error("push wrong");
	a_src_zero: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_ce && state == esiu_pkg::ESIU_MOVE_WORD2 && word2_ok && src_indirect) |=> o_dwr.wdata == esiu_pkg::ZERO_BYTE)
		else $error("indirect source not zero");
	a_dst_nop: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_ce && state == esiu_pkg::ESIU_MOVE_WORD2 && move_indexed && dst_indirect) |=> !o_dwr.we)
		else $error("indirect destination written");
	a_sub_ret: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_ce && is_sub && sel == esiu_pkg::SEL_FRAME_RET) |=> o_pc_load && o_stack.pop && o_busy)
		else $error("subtract-and-return missing");
	a_call_idle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_ce && state == esiu_pkg::ESIU_CALL_WAIT) |-> !o_ext_taken ##1 !o_busy || !i_ce)
		else $error("call not two cycles");
	a_prot_nop: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_ce && state == esiu_pkg::ESIU_MOVE_WORD2 && dst_protected) |=> !o_dwr.we)
		else $error("protected destination written");
	a_move_src: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_ce && is_move) |=> o_raddr == $past(src_addr) && o_busy)
		else $error("move source address wrong");
endmodule

// ### verif/esiu_partner.sv
// Data memory and return stack model facing the extension unit.
`timescale 1ns/1ps
module esiu_partner (
	input wire logic i_ref_clk, // Core clock.
	input wire logic [11:0] i_raddr, // Read address.
	input wire esiu_pkg::esiu_dwr_t i_dwr, // Write request.
	input wire esiu_pkg::esiu_stack_t i_stack, // Return stack request.
	output logic [7:0] o_rdata, // Read data.
	output logic [esiu_pkg::PC_W-1:0] o_tos // Return stack top.
);
	logic [7:0] mem [0:4095];
	logic [esiu_pkg::PC_W-1:0] below;
	initial begin
		for (int a = 0; a < 4096; a++) begin
			mem[a] = a[7:0] ^ 8'h5A;
		end
		o_tos = 21'h0ABCDE;
		below = 21'h012345;
	end
	// Every byte of the space is backed, so wrapped indexed addresses read real storage.
	assign o_rdata = mem[i_raddr];
	always @(posedge i_ref_clk) begin
		if (i_dwr.we) begin
			mem[i_dwr.addr] <= i_dwr.wdata;
		end
		if (i_stack.push) begin
			below <= o_tos;
			o_tos <= i_stack.push_val;
		end else if (i_stack.pop) begin
			o_tos <= below;
		end
	end
endmodule

// ### verif/extended_stack_instruction_unit_tb_top.sv
// Self-checking bench for the extension unit against its memory and stack model.
`timescale 1ns/1ps
module extended_stack_instruction_unit_tb_top;
	logic i_ref_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic fuse = 1'b0;
	logic vld = 1'b0;
	logic acc = 1'b0;
	logic ce = 1'b1;
	logic [15:0] ins = 16'h0000;
	logic [7:0] farg = 8'h00;
	logic taken, busy, pcld, imode;
	logic [7:0] rdata;
	logic [11:0] raddr, iaddr, fp;
	logic [35:0] fsp;
	logic [20:0] pcv, return_stack_top, e;
	esiu_pkg::esiu_dwr_t dwr;
	esiu_pkg::esiu_stack_t stk;
	int error_cnt = 0;
	int n_tests = 0;
	always #2.5 i_ref_clk = ~i_ref_clk;
	esiu_core i_esiu_core (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ce(ce),
		.i_extension_enable_fuse(fuse), .i_instr_valid(vld), .i_instr(ins), .i_working_register(8'h06),
		.i_counter_latch_high(8'h10), .i_counter_latch_upper(8'h01), .i_pc(21'h001000),
		.i_return_stack_top(return_stack_top), .i_rdata(rdata), .i_access_bit(acc), .i_file_arg(farg),
		.o_ext_taken(taken), .o_busy(busy), .o_raddr(raddr), .o_dwr(dwr), .o_stack(stk), .o_pc_load(pcld),
		.o_pc_value(pcv), .o_indexed_mode(imode), .o_indexed_addr(iaddr), .o_stack_frame_pointer(fp),
		.o_file_select_pointer(fsp));
	esiu_partner i_esiu_partner (.i_ref_clk(i_ref_clk), .i_raddr(raddr), .i_dwr(dwr), .i_stack(stk),
		.o_rdata(rdata), .o_tos(return_stack_top));
	task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic issue(input logic [15:0] w);
		@(posedge i_ref_clk);
		ins <= w;
		vld <= 1'b1;
		@(posedge i_ref_clk);
		vld <= 1'b0;
		#1;
	endtask
	task automatic chk_wr(input logic we, input logic [11:0] a, input logic [7:0] d);
		chk("write enable", we, dwr.we);
		if (we) begin
			chk("write address", a, dwr.addr);
			chk("write data", d, dwr.wdata);
		end
	endtask
	task automatic t_fuse_off();
		@(posedge i_ref_clk);
		ins <= 16'hE805;
		vld <= 1'b1;
		farg <= 8'h10;
		@(posedge i_ref_clk);
		#1;
		chk("taken", 1'b0, taken);
		chk("indexed mode", 1'b0, imode);
		@(posedge i_ref_clk);
		vld <= 1'b0;
		fuse <= 1'b1;
		#1;
		chk("pointers", 36'h0, fsp);
		repeat (3) @(posedge i_ref_clk);
		$display("test fuse_off done");
	endtask
	task automatic t_ptr();
		issue(16'hE83F);
		chk("pointer 0", 12'h03F, fsp[11:0]);
		chk("pc load", 1'b0, pcld);
		issue(16'hE941);
		chk("pointer 1", 12'hFFF, fsp[23:12]);
		issue(16'hE9B0);
		chk("pointer 2", 12'hFD0, fsp[35:24]);
		chk("frame pointer", 12'hFD0, fp);
		$display("test pointer_arith done");
	endtask
	// One destination is the counter low byte, and that write must be suppressed.
	task automatic t_move(input logic [15:0] w1, w2, input logic [11:0] src, input logic we,
		input logic [11:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		ins <= w1;
		vld <= 1'b1;
		@(posedge i_ref_clk);
		ins <= w2;
		#1;
		chk("source address", src, raddr);
		chk("busy", 1'b1, busy);
		chk("taken second word", 1'b1, taken);
		@(posedge i_ref_clk);
		vld <= 1'b0;
		#1;
		chk_wr(we, a, d);
		$display("test move %h done", w1);
	endtask
	task automatic t_push();
		issue(16'hE8BF);
		chk("frame pointer", 12'h00F, fp);
		issue(16'hFAAB);
		chk_wr(1'b1, 12'h00F, 8'hAB);
		chk("frame pointer", 12'h00E, fp);
		issue(16'hEACD);
		chk_wr(1'b1, 12'h00E, 8'hCD);
		chk("frame pointer", 12'h00D, fp);
		$display("test push done");
	endtask
	task automatic t_ret(input logic [15:0] w, input logic [11:0] f);
		e = return_stack_top;
		issue(w);
		chk("frame pointer", f, fp);
		chk("pop", 1'b1, stk.pop);
		chk("pc load", 1'b1, pcld);
		chk("pc value", e, pcv);
		chk("busy", 1'b1, busy);
		@(posedge i_ref_clk);
		#1;
		chk("busy end", 1'b0, busy);
		chk("pc load end", 1'b0, pcld);
		$display("test return %h done", w);
	endtask
	task automatic t_call();
		issue(16'h0014);
		chk("push", 1'b1, stk.push);
		chk("push value", 21'h001002, stk.push_val);
		chk("pc value", 21'h011006, pcv);
		chk("pc load", 1'b1, pcld);
		chk("frame pointer", 12'h010, fp);
		chk("busy", 1'b1, busy);
		@(posedge i_ref_clk);
		#1;
		chk("busy end", 1'b0, busy);
		$display("test call done");
	endtask
	task automatic t_indexed();
		@(posedge i_ref_clk);
		farg <= 8'h5F;
		#1;
		chk("indexed mode", 1'b1, imode);
		chk("indexed address", 12'h06F, iaddr);
		@(posedge i_ref_clk);
		farg <= 8'h60;
		#1;
		chk("indexed above limit", 1'b0, imode);
		@(posedge i_ref_clk);
		acc <= 1'b1;
		farg <= 8'h10;
		#1;
		chk("indexed banked", 1'b0, imode);
		$display("test indexed done");
	endtask
	// An add offered while the clock enable is low must leave pointer 0 as it was.
	task automatic t_ce();
		@(posedge i_ref_clk);
		ce <= 1'b0;
		ins <= 16'hE801;
		vld <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		vld <= 1'b0;
		ce <= 1'b1;
		#1;
		chk("frozen pointer 0", 12'h03F, fsp[11:0]);
		$display("test clock_enable done");
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		t_fuse_off();
		t_ptr();
		t_move(16'hEB8B, 16'hF07F, 12'hFDB, 1'b1, 12'h04F, 8'h00);
		t_move(16'hEB80, 16'hF01F, 12'hFD0, 1'b0, 12'h000, 8'h00);
		t_move(16'hEB05, 16'hF123, 12'hFD5, 1'b1, 12'h123, 8'hD5 ^ 8'h5A);
		t_move(16'hEB05, 16'hFFF9, 12'hFD5, 1'b0, 12'h000, 8'h00);
		t_move(16'hEB05, 16'h0123, 12'hFD5, 1'b0, 12'h000, 8'h00);
		t_push();
		t_ret(16'hE8C5, 12'h012);
		t_ret(16'hE9C2, 12'h010);
		t_call();
		t_indexed();
		t_ce();
		report_and_stop();
	end
	initial begin
		#20000;
		error_cnt++;
		report_and_stop();
	end
endmodule
